/* File: pkg/pmc_regs.svh */
// register offsets, field positions, reset values for the power-management block
// assumes byte offsets inside the function's configuration space
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// ========================================
// offsets (byte addresses in config space)
`define PMC_OFS_CAP 8'ha2
`define PMC_OFS_CSR 8'ha4

// ========================================
// capability word fields
`define PMC_CAP_D3COLD_BIT 15
`define PMC_CAP_AUX_BIT 4
`define PMC_CAP_CLK_BIT 3
`define PMC_CAP_WAKE_FIXED 4'hf
`define PMC_CAP_D2D1 2'h3
`define PMC_CAP_VERSION 3'h2
`define PMC_CAP_RESET 16'hfe12

// ========================================
// control/status word fields
`define PMC_CSR_STATUS_BIT 15
`define PMC_CSR_ENABLE_BIT 8
`define PMC_CSR_RESET 16'h0000

`endif

/* File: pkg/pmc_pkg.sv */
// types shared by the power-management register block
// assumes the register header is included by whoever needs the numbers
package pmc_pkg;

  // power state encoding of the two-bit field
  typedef enum logic [1:0] {
    PMC_D0 = 2'h0,
    PMC_D1 = 2'h1,
    PMC_D2 = 2'h2,
    PMC_D3HOT = 2'h3
  } pmc_dstate_e;

  // one configuration access, dword aligned
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pmc_cfg_req_s;

  // read answer, one cycle after the request
  typedef struct packed {
    logic rd_valid;
    logic [31:0] rdata;
  } pmc_cfg_rsp_s;

endpackage

/* File: hw/pmc_sync.sv */
// two-flop synchroniser for levels arriving from outside the clock domain
// assumes the caller freezes it with the same clock enable as the rest
`timescale 1ns/1ps
module pmc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  always_comb begin
    next_meta = ce_i ? d_i : meta;
    next_q = ce_i ? meta : q_o;
  end

  // first stage feeds the second stage only
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= RESET_VAL;
      q_o <= RESET_VAL;
    end else begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end

endmodule

/* File: hw/pmc_regs.sv */
// power-management capability and control/status words of one bridge function
// assumes config accesses and wake events arrive on clk_i; bus reset is an async pin
`timescale 1ns/1ps
`include "pmc_regs.svh"

// Operation
// (R1) capability wake-state mask is five bits, reads 11111b by default
// (R2) capability bit 15, wake from cold, is writable and defaults to one
// (R3) capability bits 14 to 11 are read-only ones
// (R4) capability bits 10 and 9 read one: D2 and D1 supported
// (R5) capability bits 8 to 6 are reserved and read zero
// (R6) capability bit 5 reads zero: no special initialization needed
// (R7) aux-supply bit reads zero whenever bit 15 is zero
// (R8) capability bit 3 is read-only: wake needs the bus clock or not
// (R9) capability bits 2 to 0 read version 010b
// (R10) writable capability bits restore only on global reset, not bus reset
// (R11) D3hot to D0 move pulses internal reset for other registers
// (R12) control/status word keeps its value across that internal reset
// (R13) wake status sets on every wake event regardless of enable
// (R14) writing one to wake status clears it and releases wake; zero ignored
// (R15) data scale and data select fields read zero
// (R16) bit 8 is wake enable; clear means wake never driven
// (R17) wake enable ignores bus reset; only global reset clears it
// (R18) control/status bits 7 to 2 read zero
// (R19) power-state field reads current state; a write moves to new state
// (R20) wake status survives bus reset while wake is enabled
// (R21) wake pin driven while wake status and wake enable are both set
module pmc_regs #(
  parameter logic AUX_NEEDED = 1'b1,
  parameter logic WAKE_NEEDS_CLK = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic bus_reset_in_b_i,
  input wire pmc_pkg::pmc_cfg_req_s cfg_req_i,
  input wire logic wake_event_i,
  output pmc_pkg::pmc_cfg_rsp_s cfg_rsp_o,
  output pmc_pkg::pmc_dstate_e power_state_o,
  output logic internal_reset_o,
  output logic wake_n_o,
  output logic wake_oe_b_o
);
  import pmc_pkg::*;

  // ========================================
  // bus reset pin crossing
  logic bus_reset_sync_b;
  logic bus_rst;

  pmc_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b1)
  ) u_bus_reset_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .d_i(bus_reset_in_b_i),
    .q_o(bus_reset_sync_b)
  );

  assign bus_rst = ~bus_reset_sync_b;

  // ========================================
  // access decode
  logic hit_cap;
  logic hit_csr;
  logic wr_cap_hi;
  logic wr_csr_lo;
  logic wr_csr_hi;

  // sized copies so the dword compare and the reset bit pick are exact width
  localparam logic [7:0] OFS_CAP = `PMC_OFS_CAP;
  localparam logic [7:0] OFS_CSR = `PMC_OFS_CSR;
  localparam logic [15:0] CAP_RESET = `PMC_CAP_RESET;

  assign hit_cap = cfg_req_i.addr[7:2] == OFS_CAP[7:2];
  assign hit_csr = cfg_req_i.addr[7:2] == OFS_CSR[7:2];
  assign wr_cap_hi = ce_i && cfg_req_i.wr && hit_cap && cfg_req_i.be[3];
  assign wr_csr_lo = ce_i && cfg_req_i.wr && hit_csr && cfg_req_i.be[0];
  assign wr_csr_hi = ce_i && cfg_req_i.wr && hit_csr && cfg_req_i.be[1];

  // ========================================
  // capability word
  logic cap_d3cold;
  logic next_cap_d3cold;
  logic [15:0] cap_word;

  always_comb begin
    next_cap_d3cold = cap_d3cold;
    // bus reset deliberately absent here
    if (wr_cap_hi) begin
      next_cap_d3cold = cfg_req_i.wdata[16 + `PMC_CAP_D3COLD_BIT]; // R2 R10
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cap_d3cold <= CAP_RESET[`PMC_CAP_D3COLD_BIT]; // R2 R10
    end else begin
      cap_d3cold <= next_cap_d3cold;
    end
  end

  always_comb begin
    cap_word = '0;
    cap_word[15] = cap_d3cold; // R1
    cap_word[14:11] = `PMC_CAP_WAKE_FIXED; // R1 R3
    cap_word[10:9] = `PMC_CAP_D2D1; // R4
    cap_word[8:5] = 4'h0; // R5 R6
    cap_word[`PMC_CAP_AUX_BIT] = AUX_NEEDED & cap_d3cold; // R7
    cap_word[`PMC_CAP_CLK_BIT] = WAKE_NEEDS_CLK; // R8
    cap_word[2:0] = `PMC_CAP_VERSION; // R9
  end

  // ========================================
  // control/status word
  pmc_dstate_e power_state;
  pmc_dstate_e next_power_state;
  logic wake_enable;
  logic next_wake_enable;
  logic wake_status;
  logic next_wake_status;
  logic next_internal_reset;
  logic [15:0] csr_word;

  always_comb begin
    next_power_state = power_state;
    next_wake_enable = wake_enable;
    next_wake_status = wake_status;
    next_internal_reset = internal_reset_o;
    if (ce_i) begin
      next_internal_reset = 1'b0;
      // bus reset wins over a state write in the same cycle
      if (bus_rst) begin
        next_power_state = PMC_D0;
      end else if (wr_csr_lo) begin
        next_power_state = pmc_dstate_e'(cfg_req_i.wdata[1:0]); // R19
        // other registers reset, this word left alone
        next_internal_reset = power_state == PMC_D3HOT &&
                              cfg_req_i.wdata[1:0] == PMC_D0; // R11 R12
      end
      if (wr_csr_hi) begin
        next_wake_enable = cfg_req_i.wdata[`PMC_CSR_ENABLE_BIT]; // R16 R17
      end
      // set wins over any clear in the same cycle
      if (wake_event_i) begin
        next_wake_status = 1'b1; // R13
      end else if (wr_csr_hi && cfg_req_i.wdata[`PMC_CSR_STATUS_BIT]) begin
        next_wake_status = 1'b0; // R14
      end else if (bus_rst && !wake_enable) begin
        next_wake_status = 1'b0; // R20
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      power_state <= PMC_D0;
      wake_enable <= 1'b0;
      wake_status <= 1'b0;
      internal_reset_o <= 1'b0;
    end else begin
      power_state <= next_power_state;
      wake_enable <= next_wake_enable;
      wake_status <= next_wake_status;
      internal_reset_o <= next_internal_reset;
    end
  end

  always_comb begin
    csr_word = `PMC_CSR_RESET;
    csr_word[`PMC_CSR_STATUS_BIT] = wake_status;
    csr_word[14:9] = 6'h00; // R15
    csr_word[`PMC_CSR_ENABLE_BIT] = wake_enable;
    csr_word[7:2] = 6'h00; // R18
    csr_word[1:0] = power_state; // R19
  end

  // ========================================
  // wake pin and outputs
  logic next_wake_oe_b;
  pmc_dstate_e next_power_state_o;

  always_comb begin
    next_wake_oe_b = wake_oe_b_o;
    next_power_state_o = power_state_o;
    if (ce_i) begin
      // open drain: pull low only while both bits are set
      next_wake_oe_b = !(wake_status && wake_enable); // R14 R16 R21
      next_power_state_o = power_state;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_oe_b_o <= 1'b1;
      wake_n_o <= 1'b0;
      power_state_o <= PMC_D0;
    end else begin
      wake_oe_b_o <= next_wake_oe_b;
      wake_n_o <= 1'b0;
      power_state_o <= next_power_state_o;
    end
  end

  // ========================================
  // read path: dword at the capability offset carries the word in its upper half
  pmc_cfg_rsp_s next_rsp;

  always_comb begin
    next_rsp = cfg_rsp_o;
    if (ce_i) begin
      next_rsp.rd_valid = cfg_req_i.rd;
      // any other dword still answers, with zeros
      next_rsp.rdata = 32'h0000_0000;
      if (cfg_req_i.rd && hit_cap) begin
        next_rsp.rdata = {cap_word, 16'h0000};
      end else if (cfg_req_i.rd && hit_csr) begin
        next_rsp.rdata = {16'h0000, csr_word};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_rsp_o <= '0;
    end else begin
      cfg_rsp_o <= next_rsp;
    end
  end

  // ========================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_CAP_WAKE_MASK: assert property (cap_word[14:11] == 4'hf) // R3
    else $error("capability wake bits 14..11 not all ones");
  AST_CAP_STATES: assert property (cap_word[10:9] == 2'h3) // R4
    else $error("capability D1/State_two_supported bits wrong");
  AST_CAP_ZERO_BITS: assert property (cap_word[8:5] == 4'h0) // R5
    else $error("capability bits 8..5 not zero");
  AST_CAP_AUX: assert property (!cap_word[15] |-> !cap_word[4]) // R7
    else $error("aux bit set while cold wake bit clear");
  AST_CAP_VERSION: assert property (cap_word[2:0] == 3'h2) // R9
    else $error("capability version not 010b");
  AST_CSR_ZEROS: assert property (csr_word[14:9] == 6'h00 && csr_word[7:2] == 6'h00) // R15 R18
    else $error("control/status reserved or data bits not zero");
  AST_WAKE_SET: assert property (ce_i && !wake_event_i && !wake_status |=> !wake_status) // R13
    else $error("wake status set without a wake event");
  AST_WAKE_SET_NOW: assert property (ce_i && wake_event_i |=> wake_status) // R13
    else $error("wake status missed an event");
  AST_WAKE_CLEAR: assert property (wr_csr_hi && cfg_req_i.wdata[15] && !wake_event_i // R14
                                   |=> !wake_status ##1 (wake_oe_b_o || !$past(ce_i)))
    else $error("write one did not clear status and release wake");
  AST_WAKE_PIN: assert property ($past(ce_i) |-> wake_oe_b_o == // R21
                                 !($past(wake_status) && $past(wake_enable)))
    else $error("wake pin does not follow status and enable");
  AST_ENABLE_BUS_RST: assert property (ce_i && bus_rst && !wr_csr_hi |=> $stable(wake_enable)) // R17
    else $error("bus reset disturbed wake enable");
  AST_STATUS_KEPT: assert property (ce_i && bus_rst && wake_enable && wake_status && // R20
                                    !(wr_csr_hi && cfg_req_i.wdata[15]) |=> wake_status)
    else $error("bus reset cleared status while wake enabled");
  AST_COLD_BUS_RST: assert property (ce_i && bus_rst && !wr_cap_hi |=> $stable(cap_d3cold)) // R10
    else $error("bus reset disturbed cold wake bit");
  AST_STATE_WRITE: assert property (wr_csr_lo && !bus_rst // R19
                                    |=> power_state == $past(cfg_req_i.wdata[1:0]))
    else $error("power state write not taken");
  AST_INT_RESET: assert property (wr_csr_lo && !bus_rst && power_state == PMC_D3HOT && // R11 R12
                                  cfg_req_i.wdata[1:0] == 2'h0
                                  |=> internal_reset_o && power_state == PMC_D0
                                  && wake_enable == $past(wr_csr_hi ? cfg_req_i.wdata[8]
                                  : wake_enable))
    else $error("D3hot to D0 move mishandled");

  // ========================================
  // checks on what the bus, the resets and the enable may change
  AST_IRST_ONLY: assert property (ce_i && !(wr_csr_lo && !bus_rst && // R11
                                  power_state == PMC_D3HOT && cfg_req_i.wdata[1:0] == 2'h0)
                                  |=> !internal_reset_o)
    else $error("internal reset pulse without a D3hot to D0 write");
  AST_ENABLE_OFF: assert property (ce_i && !wake_enable |=> wake_oe_b_o) // R16
    else $error("wake pin driven while wake disabled");
  AST_ZERO_WRITE: assert property (wr_csr_hi && !cfg_req_i.wdata[15] && wake_status // R14
                                   && !bus_rst |=> wake_status)
    else $error("writing zero cleared wake status");
  AST_STATUS_BUS_CLR: assert property (ce_i && bus_rst && !wake_enable && !wake_event_i // R20
                                       |=> !wake_status)
    else $error("bus reset left status set while wake disabled");
  AST_CAP_COLD_WRITE: assert property (wr_cap_hi // R2
                                       |=> cap_d3cold == $past(cfg_req_i.wdata[31]))
    else $error("cold wake bit write not taken");
  AST_CAP_CLK: assert property (cap_word[3] == WAKE_NEEDS_CLK) // R8
    else $error("capability clock bit wrong");
  AST_CAP_AUX_SET: assert property (cap_word[15] |-> cap_word[4] == AUX_NEEDED) // R7
    else $error("aux bit wrong while cold wake bit set");
  AST_STATE_BUS_RST: assert property (ce_i && bus_rst |=> power_state == PMC_D0) // R19
    else $error("bus reset did not return power state to D0");
  AST_STATE_OUT: assert property ($past(ce_i) |-> power_state_o == $past(power_state)) // R19
    else $error("power state output does not follow the field");
  AST_RSP_VALID: assert property (ce_i |=> cfg_rsp_o.rd_valid == $past(cfg_req_i.rd)) // R19
    else $error("read answer not one cycle after the read");
  AST_FREEZE: assert property (!ce_i |=> $stable(power_state) && // R17
                               $stable(wake_status) && $stable(wake_enable) &&
                               $stable(cap_d3cold) && $stable(internal_reset_o))
    else $error("state changed while clock enable low");

endmodule

/* File: testbench/pmc_host.sv */
// host model: issues config reads and writes on the falling edge
// assumes the registers answer a read within four cycles of the first falling edge after it is taken
`timescale 1ns/1ps
module pmc_host (
  input wire logic clk_i,
  input wire pmc_pkg::pmc_cfg_rsp_s cfg_rsp_i,
  output pmc_pkg::pmc_cfg_req_s cfg_req_o
);
  import pmc_pkg::*;
  initial cfg_req_o = '0;
  // ========================================
  // bus cycles
  // request held across the taking edge; released lines show inverted data
  task automatic wr(input logic [7:0] a, input logic [3:0] e, input logic [31:0] d);
    @(negedge clk_i);
    cfg_req_o = '{1'b1, 1'b0, a, e, d};
    @(negedge clk_i);
    cfg_req_o = '{1'b0, 1'b0, ~a, ~e, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
    int n;
    @(negedge clk_i);
    cfg_req_o = '{1'b0, 1'b1, a, 4'hf, 32'h0000_0000};
    @(negedge clk_i);
    cfg_req_o = '{1'b0, 1'b0, ~a, 4'h0, 32'hffff_ffff};
    n = 0;
    while (cfg_rsp_i.rd_valid !== 1'b1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    ok = (cfg_rsp_i.rd_valid === 1'b1);
    d = cfg_rsp_i.rdata;
  endtask
endmodule

/* File: testbench/pmc_regs_tb.sv */
// self-checking bench for the power-management register block
// assumes the host model drives every config access
`timescale 1ns/1ps
`include "pmc_regs.svh"
module pmc_regs_tb;
  import pmc_pkg::*;
  typedef struct {
    logic [7:0] a;
    logic [3:0] e;
    logic [31:0] d;
    logic [31:0] x;
  } pmc_row_s;
  logic clk_i;
  logic rst_b_i;
  logic ce_i;
  logic bus_reset_in_b_i;
  logic wake_event_i;
  pmc_cfg_req_s req;
  pmc_cfg_rsp_s rsp;
  pmc_dstate_e state;
  logic irst;
  logic wake_n;
  logic wake_oe_b;
  logic [31:0] rdat;
  logic ok;
  int n_mismatch;
  int cmp_count;
  pmc_row_s rows [6] = '{
    '{`PMC_OFS_CAP, 4'h8, 32'h0000_0000, 32'h7e02_0000},
    '{`PMC_OFS_CAP, 4'h7, 32'h0000_0000, 32'h7e02_0000},
    '{`PMC_OFS_CAP, 4'hf, 32'hffff_ffff, 32'hfe12_0000},
    '{`PMC_OFS_CSR, 4'h3, 32'h0000_7fff, 32'h0000_0103},
    '{`PMC_OFS_CSR, 4'h1, 32'h0000_0002, 32'h0000_0102},
    '{8'ha8, 4'hf, 32'hffff_ffff, 32'h0000_0000}
  };

  pmc_regs pmc_regs_i (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .bus_reset_in_b_i(bus_reset_in_b_i),
    .cfg_req_i(req),
    .wake_event_i(wake_event_i),
    .cfg_rsp_o(rsp),
    .power_state_o(state),
    .internal_reset_o(irst),
    .wake_n_o(wake_n),
    .wake_oe_b_o(wake_oe_b)
  );
  pmc_host pmc_host_i (
    .clk_i(clk_i),
    .cfg_rsp_i(rsp),
    .cfg_req_o(req)
  );

  // ========================================
  // helpers
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    pmc_host_i.rd(a, rdat, ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end
    chk(rdat, x);
  endtask
  // bus reset pin is synchronised, so hold it long enough to land
  task automatic breset();
    bus_reset_in_b_i = 1'b0;
    repeat (5) @(negedge clk_i);
    bus_reset_in_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic wake();
    @(negedge clk_i);
    wake_event_i = 1'b1;
    @(negedge clk_i);
    wake_event_i = 1'b0;
    @(negedge clk_i);
  endtask

  // ========================================
  // stimulus
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    bus_reset_in_b_i = 1'b1;
    wake_event_i = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (6) @(negedge clk_i);
    rst_b_i = 1'b1;
    rdchk(`PMC_OFS_CAP, 32'hfe12_0000);
    rdchk(`PMC_OFS_CSR, 32'h0000_0000);
    foreach (rows[i]) begin
      pmc_host_i.wr(rows[i].a, rows[i].e, rows[i].d);
      rdchk(rows[i].a, rows[i].x);
    end
    pmc_host_i.wr(`PMC_OFS_CSR, 4'h1, 32'h0000_0003);
    @(negedge clk_i);
    chk(state, PMC_D3HOT);
    pmc_host_i.wr(`PMC_OFS_CSR, 4'h1, 32'h0000_0000);
    chk(irst, 1'b1);
    @(negedge clk_i);
    chk(irst, 1'b0);
    chk(state, PMC_D0);
    rdchk(`PMC_OFS_CSR, 32'h0000_0100);
    wake();
    chk({wake_oe_b, wake_n}, 2'b00);
    pmc_host_i.wr(`PMC_OFS_CSR, 4'h2, 32'h0000_0100);
    rdchk(`PMC_OFS_CSR, 32'h0000_8100);
    breset();
    rdchk(`PMC_OFS_CSR, 32'h0000_8100);
    pmc_host_i.wr(`PMC_OFS_CSR, 4'h2, 32'h0000_8100);
    @(negedge clk_i);
    chk(wake_oe_b, 1'b1);
    rdchk(`PMC_OFS_CSR, 32'h0000_0100);
    // enable off: status still latches, pin must stay released
    pmc_host_i.wr(`PMC_OFS_CSR, 4'h2, 32'h0000_0000);
    wake();
    @(negedge clk_i);
    chk(wake_oe_b, 1'b1);
    rdchk(`PMC_OFS_CSR, 32'h0000_8000);
    breset();
    rdchk(`PMC_OFS_CSR, 32'h0000_0000);
    pmc_host_i.wr(`PMC_OFS_CAP, 4'h8, 32'h0000_0000);
    pmc_host_i.wr(`PMC_OFS_CSR, 4'h3, 32'h0000_0101);
    breset();
    rdchk(`PMC_OFS_CAP, 32'h7e02_0000);
    rdchk(`PMC_OFS_CSR, 32'h0000_0100);
    // event and write-one-clear in one cycle: the event must win
    fork
      pmc_host_i.wr(`PMC_OFS_CSR, 4'h2, 32'h0000_8100);
      wake();
    join
    rdchk(`PMC_OFS_CSR, 32'h0000_8100);
    chk(wake_oe_b, 1'b0);
    // clock enable low: the write must leave no trace
    ce_i = 1'b0;
    pmc_host_i.wr(`PMC_OFS_CSR, 4'h3, 32'h0000_0002);
    ce_i = 1'b1;
    rdchk(`PMC_OFS_CSR, 32'h0000_8100);
    chk(state, PMC_D0);
    @(negedge clk_i);
    rst_b_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_b_i = 1'b1;
    rdchk(`PMC_OFS_CAP, 32'hfe12_0000);
    rdchk(`PMC_OFS_CSR, 32'h0000_0000);
    chk(wake_oe_b, 1'b1);
    stop_test();
  end
endmodule
